// ---- bench/tb_top.sv ----
// testbench top: drives the bus-state and irq-mask block over wishbone
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
    logic mclk_i, rst_n_i, ce_i, speed_valid, speed_full, irq, attach, full;
    usb_bus_ctl_pkg::wb_req_t wb_req;
    usb_bus_ctl_pkg::wb_rsp_t wb_rsp;
    usb_bus_ctl_pkg::line_drive_t line;
    logic [11:0] ctl_ev;
    logic [31:0] ep_ev;
    int err_total, checks_done;

    usb_bus_ctl u_usb_bus_ctl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .control_irq_bits_i(ctl_ev),
        .endpoint_irq_bits_i(ep_ev), .speed_valid_i(speed_valid), .speed_full_i(speed_full),
        .line_o(line), .irq_o(irq));
    usb_dev_model u_usb_dev_model (.mclk_i(mclk_i), .attach_i(attach), .full_i(full),
        .speed_valid_o(speed_valid), .speed_full_o(speed_full));

    // =====================================================================
    // bus master and helpers
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // request held until ack is sampled; bounded so a dead slave cannot hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge mclk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (wb_rsp.ack !== 1'b1 && n < 40);
        `CHK(wb_rsp.ack, 1'b1)
        q = wb_rsp.dat;
        wb_req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        `CHK(q, exp)
    endtask

    // control write, then the line state two edges later
    task automatic ctl_line(input logic [31:0] d, input logic [2:0] exp);
        wr(usb_bus_ctl_pkg::OFF_BUS_CTRL, d);
        repeat (2) @(posedge mclk_i);
        #1;
        `CHK(line, exp)
    endtask

    // one-cycle event, then wait for pending and the irq register
    task automatic pulse(input logic [11:0] c, input logic [31:0] e);
        @(posedge mclk_i);
        ctl_ev <= c;
        ep_ev <= e;
        @(posedge mclk_i);
        ctl_ev <= 12'h000;
        ep_ev <= 32'h0000_0000;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    task automatic spd(input logic a, input logic f, input logic [1:0] code);
        @(posedge mclk_i);
        attach <= a;
        full <= f;
        repeat (8) @(posedge mclk_i);
        rd(usb_bus_ctl_pkg::OFF_BUS_STAT, {26'h0, code, 4'h0});
    endtask

    // =====================================================================
    // scenarios
    task automatic t_reset_vals();
        logic [7:0] offs [7] = '{8'h00, 8'h10, 8'h1c, 8'h20, 8'h2c, 8'h30, 8'h3c};
        for (int i = 0; i < 7; i++)
            rd(offs[i], 32'h0000_0000);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_speed();
        spd(1'b1, 1'b0, usb_bus_ctl_pkg::SPEED_LOW);
        spd(1'b1, 1'b1, usb_bus_ctl_pkg::SPEED_FULL);
        spd(1'b0, 1'b0, usb_bus_ctl_pkg::speed_unknown_code);
    endtask

    task automatic t_bus_states();
        ctl_line(32'h9, 3'b100);
        rd(usb_bus_ctl_pkg::OFF_BUS_STAT, 32'h0000_0031);
        ctl_line(32'h8, 3'b000);
        ctl_line(32'h1, 3'b000);
        ctl_line(32'hc, 3'b001);
        ctl_line(32'ha, 3'b010);
        ctl_line(32'h8, 3'b000);
        ctl_line(32'h4, 3'b000);
        ctl_line(32'h2, 3'b010);
        ctl_line(32'h0, 3'b000);
    endtask

    task automatic t_ctl_irq();
        wr(usb_bus_ctl_pkg::OFF_CTL_SET, 32'h0000_0fff);
        rd(usb_bus_ctl_pkg::OFF_CTL_MASK, 32'h0000_0fff);
        wr(usb_bus_ctl_pkg::OFF_CTL_CLR, 32'h0000_00ff);
        rd(usb_bus_ctl_pkg::OFF_CTL_MASK, 32'h0000_0f00);
        for (int i = 0; i < 12; i++)
        begin
            pulse(12'h001 << i, 32'h0000_0000);
            `CHK(irq, logic'(i >= 8))
            rd(usb_bus_ctl_pkg::OFF_CTL_STAT, 32'h1 << i);
            rd(usb_bus_ctl_pkg::OFF_CTL_STAT, 32'h0000_0000);
            `CHK(irq, 1'b0)
        end
    endtask

    task automatic t_ep_irq();
        wr(usb_bus_ctl_pkg::OFF_EP_SET, 32'h0002_0000);
        pulse(12'h000, 32'h0002_0008);
        `CHK(irq, 1'b1)
        rd(usb_bus_ctl_pkg::OFF_EP_STAT, 32'h0002_0008);
        rd(usb_bus_ctl_pkg::OFF_EP_STAT, 32'h0000_0000);
        `CHK(irq, 1'b0)
        pulse(12'h000, 32'h0000_0008);
        `CHK(irq, 1'b0)
        rd(usb_bus_ctl_pkg::OFF_EP_STAT, 32'h0000_0008);
        wr(usb_bus_ctl_pkg::OFF_EP_CLR, 32'h0002_0000);
        rd(usb_bus_ctl_pkg::OFF_EP_MASK, 32'h0000_0000);
    endtask

    task automatic t_legacy();
        logic [31:0] q;
        wr(usb_bus_ctl_pkg::OFF_LEG_SET, 32'h0000_0041);
        rd(usb_bus_ctl_pkg::OFF_EP_MASK, 32'h0004_0001);
        wr(usb_bus_ctl_pkg::OFF_LEG_CLR, 32'h0000_0001);
        rd(usb_bus_ctl_pkg::OFF_EP_MASK, 32'h0004_0000);
        wr(usb_bus_ctl_pkg::OFF_LEG_SET, 32'h8000_0000);
        rd(usb_bus_ctl_pkg::OFF_CTL_MASK, 32'h0000_0fff);
        rd(usb_bus_ctl_pkg::OFF_LEG_MASK, 32'h0001_00ff);
        xfer(1'b0, usb_bus_ctl_pkg::OFF_EP_MASK, 32'h0000_0000, q);
        `CHK(q & 32'h000f_000f, 32'h000f_000f)
        wr(usb_bus_ctl_pkg::OFF_LEG_CLR, 32'h8000_0000);
        rd(usb_bus_ctl_pkg::OFF_CTL_MASK, 32'h0000_0000);
        rd(usb_bus_ctl_pkg::OFF_EP_MASK, 32'h0000_0000);
    endtask

    // frozen clock enable: events seen while ce_i is low must not latch
    task automatic t_freeze();
        @(posedge mclk_i);
        ce_i <= 1'b0;
        pulse(12'h800, 32'h0000_0008);
        @(posedge mclk_i);
        ce_i <= 1'b1;
        rd(usb_bus_ctl_pkg::OFF_CTL_STAT, 32'h0000_0000);
        rd(usb_bus_ctl_pkg::OFF_EP_STAT, 32'h0000_0000);
    endtask

    // =====================================================================
    // clock, watchdog and main sequence
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // the whole run needs a few hundred cycles; reaching 20000 means a hang
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        finish_test();
    end

    initial
    begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        wb_req = '0;
        ctl_ev = 12'h000;
        ep_ev = 32'h0000_0000;
        attach = 1'b0;
        full = 1'b0;
        err_total = 0;
        checks_done = 0;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_reset_vals();
        t_speed();
        t_bus_states();
        t_ctl_irq();
        t_ep_irq();
        t_legacy();
        t_freeze();
        finish_test();
    end
endmodule // tb_top

// ---- bench/usb_bus_ctl_monitor.sv ----
// checker for the bus-state and irq-mask block, bound to its top
`timescale 1ns/10ps
module usb_bus_ctl_monitor (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // wishbone
    input wire usb_bus_ctl_pkg::wb_req_t wb_req_i,
    input wire usb_bus_ctl_pkg::wb_rsp_t wb_rsp_o,
    // events and speed pins
    input wire logic [usb_bus_ctl_pkg::CTL_W-1:0] control_irq_bits_i,
    input wire logic [usb_bus_ctl_pkg::EP_W-1:0] endpoint_irq_bits_i,
    input wire logic speed_valid_i,
    input wire logic speed_full_i,
    // outputs
    input wire usb_bus_ctl_pkg::line_drive_t line_o,
    input wire logic irq_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // =====================================================================
    // steps of a control write and of a settled speed read
    sequence ctrl_wr;
        wb_rsp_o.ack && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0]
            && wb_req_i.adr == usb_bus_ctl_pkg::OFF_BUS_CTRL;
    endsequence
    // two sync flops plus the read register need five steady samples
    sequence spd_settled;
        ($stable(speed_valid_i) && $stable(speed_full_i)) [*5];
    endsequence

    // =====================================================================
    // handshake
    ack_answer_a: assert property ((wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && ce_i)
        |=> wb_rsp_o.ack) else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");

    // =====================================================================
    // line states and speed code
    rst_drive_a: assert property (ctrl_wr ##0 (wb_req_i.dat[0] && wb_req_i.dat[3])
        |=> line_o.drive_reset) else $error("bus reset not driven");
    rst_gate_a: assert property (ctrl_wr ##0 !wb_req_i.dat[0]
        |=> !line_o.drive_reset) else $error("bus reset still driven");
    resume_on_a: assert property (ctrl_wr ##0 wb_req_i.dat[1]
        |=> line_o.drive_resume && !line_o.suspended) else $error("resume not driven");
    resume_off_a: assert property (ctrl_wr ##0 !wb_req_i.dat[1]
        |=> !line_o.drive_resume) else $error("resume not finished");
    suspend_set_a: assert property (ctrl_wr ##0 (wb_req_i.dat[2] && wb_req_i.dat[3]
        && !wb_req_i.dat[1]) |=> line_o.suspended) else $error("bus not suspended");
    speed_code_a: assert property (spd_settled ##0 (wb_rsp_o.ack && !wb_req_i.we
        && wb_req_i.adr == usb_bus_ctl_pkg::OFF_BUS_STAT) |-> wb_rsp_o.dat[5:4] ==
        (speed_valid_i ? (speed_full_i ? usb_bus_ctl_pkg::SPEED_FULL : usb_bus_ctl_pkg::SPEED_LOW)
        : usb_bus_ctl_pkg::speed_unknown_code)) else $error("speed code wrong");
endmodule // usb_bus_ctl_monitor

bind usb_bus_ctl usb_bus_ctl_monitor u_usb_bus_ctl_monitor (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .control_irq_bits_i(control_irq_bits_i), .endpoint_irq_bits_i(endpoint_irq_bits_i),
    .speed_valid_i(speed_valid_i), .speed_full_i(speed_full_i), .line_o(line_o), .irq_o(irq_o));

// ---- bench/usb_dev_model.sv ----
// far-side peripheral model: speed indication lines of the attached device
`timescale 1ns/10ps
module usb_dev_model (
    // clock
    input wire logic mclk_i,
    // scenario controls
    input wire logic attach_i,
    input wire logic full_i,
    // pin side toward the block
    output logic speed_valid_o,
    output logic speed_full_o
);
    // =====================================================================
    // speed lines
    // a detached line floats: show the inverse so no stale level reads as a speed
    always @(posedge mclk_i)
    begin
        speed_valid_o <= attach_i;
        speed_full_o <= attach_i ? full_i : ~full_i;
    end
endmodule // usb_dev_model

// ---- pkg/usb_bus_ctl_pkg.sv ----
// package: register map, field layout and shared types of the usb bus-state and irq-mask block
package usb_bus_ctl_pkg;

    // =====================================================================
    // register byte offsets
    localparam logic [7:0] OFF_BUS_CTRL = 8'h00;
    localparam logic [7:0] OFF_BUS_STAT = 8'h04;
    localparam logic [7:0] OFF_LEG_SET = 8'h08;
    localparam logic [7:0] OFF_LEG_CLR = 8'h0c;
    localparam logic [7:0] OFF_LEG_MASK = 8'h10;
    localparam logic [7:0] OFF_CTL_SET = 8'h14;
    localparam logic [7:0] OFF_CTL_CLR = 8'h18;
    localparam logic [7:0] OFF_CTL_MASK = 8'h1c;
    localparam logic [7:0] OFF_CTL_STAT = 8'h20;
    localparam logic [7:0] OFF_EP_SET = 8'h24;
    localparam logic [7:0] OFF_EP_CLR = 8'h28;
    localparam logic [7:0] OFF_EP_MASK = 8'h2c;
    localparam logic [7:0] OFF_EP_STAT = 8'h30;

    // =====================================================================
    // bus control fields
    localparam int BIT_RESET_START = 0;
    localparam int BIT_RESUME_START = 1;
    localparam int BIT_SUSPEND_REQ = 2;
    localparam int BIT_HOST_ROLE = 3;

    // bus status fields
    localparam int BIT_ST_RESET = 0;
    localparam int BIT_ST_RESUME = 1;
    localparam int BIT_ST_SUSPEND = 2;
    localparam int BIT_ST_SPEED_LO = 4;

    // speed codes
    localparam logic [1:0] SPEED_LOW = 2'h0;
    localparam logic [1:0] SPEED_FULL = 2'h1;
    localparam logic [1:0] speed_unknown_code = 2'h3;

    // legacy grouped mask fields
    localparam int LEG_HOST_IN_LO = 0;
    localparam int LEG_HOST_OUT_LO = 4;
    localparam int LEG_DEV_IN_LO = 8;
    localparam int LEG_DEV_OUT_LO = 12;
    localparam int LEG_STATUS_LO = 16;
    localparam int LEG_ALL_BIT = 31;
    localparam int LEG_EPS = 4;

    // control irq source bits
    localparam int CTL_VBUS_ERR = 0;
    localparam int CTL_SESSION = 1;
    localparam int CTL_SESSION_END = 2;
    localparam int CTL_DISCONNECT = 3;
    localparam int CTL_CONNECT = 4;
    localparam int CTL_SOF = 5;
    localparam int CTL_BABBLE = 6;
    localparam int CTL_RESET = 7;
    localparam int CTL_RESUME = 8;
    localparam int CTL_SUSPEND = 9;
    localparam int CTL_MODE_DETECT = 10;
    localparam int CTL_POWER_FAULT = 11;
    localparam int CTL_W = 12;

    // endpoint irq layout: host in, host out, 2 x 16 per-endpoint bits
    localparam int EP_N = 16;
    localparam int EP_W = 32;

    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // =====================================================================
    // classic wishbone request and answer
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // bus line drive toward the phy
    typedef struct packed {
        logic drive_reset;
        logic drive_resume;
        logic suspended;
    } line_drive_t;

endpackage

// ---- verilog/bus_line_ctl.sv ----
// bus line state control: reset, resume and suspend signalling levels
`timescale 1ns/10ps
module bus_line_ctl (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // software controls
    input wire logic host_role_i,
    input wire logic reset_start_i,
    input wire logic resume_start_i,
    input wire logic suspend_req_i,
    // line drive
    output usb_bus_ctl_pkg::line_drive_t line_o
);

    typedef struct packed {
        usb_bus_ctl_pkg::line_drive_t line;
    } st_t;

    st_t st_q;
    st_t st_d;

    // =====================================================================
    // reset and resume drives follow the control bits; suspend holds until resume or host reset leaves it
    always_comb
    begin
        st_d = st_q;
        st_d.line.drive_reset = reset_start_i & host_role_i;
        st_d.line.drive_resume = resume_start_i;
        if (resume_start_i || (reset_start_i && host_role_i))
        begin
            st_d.line.suspended = 1'b0;
        end
        else if (suspend_req_i && host_role_i)
        begin
            st_d.line.suspended = 1'b1;
        end
    end

    // clearing resume drops the drive, finishing the sequence in one edge
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= '0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end

    assign line_o = st_q.line;

endmodule // bus_line_ctl

// ---- verilog/irq_pend_bank.sv ----
// pending irq bank: sticky sources, set/clear enable mask, clear-on-read status
`timescale 1ns/10ps
module irq_pend_bank #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // hardware events
    input wire logic [W-1:0] event_i,
    // software mask operations
    input wire logic [W-1:0] en_set_i,
    input wire logic [W-1:0] en_clr_i,
    input wire logic status_rd_i,
    // state
    output logic [W-1:0] mask_o,
    output logic [W-1:0] pend_o,
    output logic irq_o
);

    typedef struct packed {
        logic [W-1:0] mask;
        logic [W-1:0] pend;
    } st_t;

    st_t st_q;
    st_t st_d;

    // =====================================================================
    // next state: event set beats the read-clear
    always_comb
    begin
        st_d = st_q;
        st_d.mask = (st_q.mask | en_set_i) & ~en_clr_i;
        if (status_rd_i)
        begin
            st_d.pend = '0;
        end
        st_d.pend = st_d.pend | event_i;
    end

    // state register
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= '0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end

    assign mask_o = st_q.mask;
    assign pend_o = st_q.pend;
    // only enabled sources raise the line
    assign irq_o = |(st_q.pend & st_q.mask);

endmodule // irq_pend_bank

// ---- verilog/usb_bus_ctl.sv ----
// top: wishbone register file for usb bus states and interrupt masking
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
module usb_bus_ctl (
    // clock, enable and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // classic wishbone slave
    input wire usb_bus_ctl_pkg::wb_req_t wb_req_i,
    output usb_bus_ctl_pkg::wb_rsp_t wb_rsp_o,
    // event sources from the link core
    input wire logic [usb_bus_ctl_pkg::CTL_W-1:0] control_irq_bits_i,
    input wire logic [usb_bus_ctl_pkg::EP_W-1:0] endpoint_irq_bits_i,
    // attached device speed from the phy, pin side
    input wire logic speed_valid_i,
    input wire logic speed_full_i,
    // bus line drive
    output usb_bus_ctl_pkg::line_drive_t line_o,
    // interrupt line to the system controller
    output logic irq_o
);

    localparam int CW = usb_bus_ctl_pkg::CTL_W;
    localparam int EW = usb_bus_ctl_pkg::EP_W;
    // legacy groups that fit the endpoint mask: host in and host out only;
    // device in/out groups would land above the top bit, so they are dropped
    localparam int LEG_GRPS = EW / usb_bus_ctl_pkg::EP_N;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic reset_start;
        logic resume_start;
        logic suspend_req;
        logic host_role;
        logic status_en;
        logic [1:0] spd_s1;
        logic [1:0] spd_s2;
        logic irq;
    } st_t;

    st_t st_q;
    st_t st_d;

    // decoded bus actions
    logic acc;
    logic wr;
    logic rd;
    logic [31:0] wdat;
    logic [CW-1:0] ctl_set;
    logic [CW-1:0] ctl_clr;
    logic [EW-1:0] ep_set;
    logic [EW-1:0] ep_clr;
    logic [EW-1:0] leg_ep_set;
    logic [EW-1:0] leg_ep_clr;
    logic ctl_rd;
    logic ep_rd;
    logic [CW-1:0] ctl_mask;
    logic [CW-1:0] ctl_pend;
    logic [EW-1:0] ep_mask;
    logic [EW-1:0] ep_pend;
    logic ctl_irq;
    logic ep_irq;
    logic [1:0] speed;
    logic [31:0] leg_view;

    // =====================================================================
    // wishbone decode: one access per request, ack in the next cycle
    assign acc = wb_req_i.cyc & wb_req_i.stb & ~st_q.ack;
    assign wr = acc & wb_req_i.we;
    assign rd = acc & ~wb_req_i.we;
    // byte lanes gate write data
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            wdat[i*8 +: 8] = wb_req_i.sel[i] ? wb_req_i.dat[i*8 +: 8] : 8'h00;
        end
    end

    // =====================================================================
    // legacy grouped mask maps onto endpoints 0..3 of the endpoint mask
    genvar g;
    generate
        for (g = 0; g < LEG_GRPS; g++)
        begin : g_leg
            logic hit_set;
            logic hit_clr;
            logic [usb_bus_ctl_pkg::LEG_EPS-1:0] grp;
            assign hit_set = wr && (wb_req_i.adr == usb_bus_ctl_pkg::OFF_LEG_SET);
            assign hit_clr = wr && (wb_req_i.adr == usb_bus_ctl_pkg::OFF_LEG_CLR);
            // all selector widens to endpoints 0..3 of the group
            assign grp = wdat[usb_bus_ctl_pkg::LEG_ALL_BIT] ? '1
                : wdat[g*usb_bus_ctl_pkg::LEG_EPS +: usb_bus_ctl_pkg::LEG_EPS];
            // only endpoints 0..3 reachable here, higher ones untouched
            assign leg_ep_set[g*usb_bus_ctl_pkg::EP_N +: usb_bus_ctl_pkg::EP_N] =
                hit_set ? {12'h000, grp} : 16'h0000;
            assign leg_ep_clr[g*usb_bus_ctl_pkg::EP_N +: usb_bus_ctl_pkg::EP_N] =
                hit_clr ? {12'h000, grp} : 16'h0000;
        end
    endgenerate

    // =====================================================================
    // set/clear strobes into the two banks
    always_comb
    begin
        ctl_set = '0;
        ctl_clr = '0;
        ep_set = leg_ep_set;
        ep_clr = leg_ep_clr;
        if (wr && wb_req_i.adr == usb_bus_ctl_pkg::OFF_CTL_SET)
        begin
            ctl_set = wdat[CW-1:0];
        end
        if (wr && wb_req_i.adr == usb_bus_ctl_pkg::OFF_CTL_CLR)
        begin
            ctl_clr = wdat[CW-1:0];
        end
        if (wr && wb_req_i.adr == usb_bus_ctl_pkg::OFF_EP_SET)
        begin
            ep_set = ep_set | wdat;
        end
        if (wr && wb_req_i.adr == usb_bus_ctl_pkg::OFF_EP_CLR)
        begin
            ep_clr = ep_clr | wdat;
        end
        // legacy all/status also reach the control sources
        if (wr && wb_req_i.adr == usb_bus_ctl_pkg::OFF_LEG_SET
            && (wdat[usb_bus_ctl_pkg::LEG_ALL_BIT] || wdat[usb_bus_ctl_pkg::LEG_STATUS_LO]))
        begin
            ctl_set = '1;
        end
        if (wr && wb_req_i.adr == usb_bus_ctl_pkg::OFF_LEG_CLR
            && (wdat[usb_bus_ctl_pkg::LEG_ALL_BIT] || wdat[usb_bus_ctl_pkg::LEG_STATUS_LO]))
        begin
            ctl_clr = '1;
        end
    end

    // status reads clear pending sources as a side effect
    assign ctl_rd = rd && (wb_req_i.adr == usb_bus_ctl_pkg::OFF_CTL_STAT);
    assign ep_rd = rd && (wb_req_i.adr == usb_bus_ctl_pkg::OFF_EP_STAT);

    // =====================================================================
    // control sources, twelve events
    irq_pend_bank #(
        .W(CW)
    ) u_ctl_bank (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .event_i(control_irq_bits_i),
        .en_set_i(ctl_set),
        .en_clr_i(ctl_clr),
        .status_rd_i(ctl_rd),
        .mask_o(ctl_mask),
        .pend_o(ctl_pend),
        .irq_o(ctl_irq)
    );

    // endpoint sources, independent mask
    irq_pend_bank #(
        .W(EW)
    ) u_ep_bank (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .event_i(endpoint_irq_bits_i),
        .en_set_i(ep_set),
        .en_clr_i(ep_clr),
        .status_rd_i(ep_rd),
        .mask_o(ep_mask),
        .pend_o(ep_pend),
        .irq_o(ep_irq)
    );

    // =====================================================================
    // line control
    bus_line_ctl u_line (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .host_role_i(st_q.host_role),
        .reset_start_i(st_q.reset_start),
        .resume_start_i(st_q.resume_start),
        .suspend_req_i(st_q.suspend_req),
        .line_o(line_o)
    );

    // speed code from synchronised phy pins
    always_comb
    begin
        if (!st_q.spd_s2[0])
        begin
            speed = usb_bus_ctl_pkg::speed_unknown_code;
        end
        else if (st_q.spd_s2[1])
        begin
            speed = usb_bus_ctl_pkg::SPEED_FULL;
        end
        else
        begin
            speed = usb_bus_ctl_pkg::SPEED_LOW;
        end
    end

    // legacy view: endpoint 0..3 enables per group plus status
    always_comb
    begin
        leg_view = '0;
        for (int k = 0; k < LEG_GRPS; k++)
        begin
            leg_view[k*4 +: 4] = ep_mask[k*usb_bus_ctl_pkg::EP_N +: 4];
        end
        leg_view[usb_bus_ctl_pkg::LEG_STATUS_LO] = &ctl_mask;
    end

    // =====================================================================
    // register next state and read mux
    always_comb
    begin
        st_d = st_q;
        st_d.ack = acc;
        st_d.spd_s1 = {speed_full_i, speed_valid_i};
        st_d.spd_s2 = st_q.spd_s1;
        st_d.irq = ctl_irq | ep_irq;
        if (wr && wb_req_i.adr == usb_bus_ctl_pkg::OFF_BUS_CTRL)
        begin
            st_d.reset_start = wdat[usb_bus_ctl_pkg::BIT_RESET_START];
            st_d.resume_start = wdat[usb_bus_ctl_pkg::BIT_RESUME_START];
            st_d.suspend_req = wdat[usb_bus_ctl_pkg::BIT_SUSPEND_REQ];
            st_d.host_role = wdat[usb_bus_ctl_pkg::BIT_HOST_ROLE];
        end
        if (rd)
        begin
            unique case (wb_req_i.adr)
                usb_bus_ctl_pkg::OFF_BUS_CTRL:
                    st_d.rdat = {28'h0000000, st_q.host_role, st_q.suspend_req,
                        st_q.resume_start, st_q.reset_start};
                usb_bus_ctl_pkg::OFF_BUS_STAT:
                    st_d.rdat = {26'h0, speed, 1'b0, line_o.suspended,
                        line_o.drive_resume, line_o.drive_reset};
                usb_bus_ctl_pkg::OFF_LEG_MASK:
                    st_d.rdat = leg_view;
                usb_bus_ctl_pkg::OFF_CTL_MASK:
                    st_d.rdat = {20'h00000, ctl_mask};
                usb_bus_ctl_pkg::OFF_CTL_STAT:
                    st_d.rdat = {20'h00000, ctl_pend};
                usb_bus_ctl_pkg::OFF_EP_MASK:
                    st_d.rdat = ep_mask;
                usb_bus_ctl_pkg::OFF_EP_STAT:
                    st_d.rdat = ep_pend;
                default:
                    st_d.rdat = usb_bus_ctl_pkg::RST_ZERO; // unmapped and write-only read zero
            endcase
        end
    end

    // state register; clock enable freezes everything
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= '0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end

    assign wb_rsp_o.ack = st_q.ack;
    assign wb_rsp_o.dat = st_q.rdat;
    assign irq_o = st_q.irq;

endmodule // usb_bus_ctl
